/* hw/wrs_pkg.sv */
// Shared constants, field layouts and codes of the windowed register state
package wrs_pkg;

    // ****************************************
    // Geometry
    // ****************************************
    localparam int WIN_COUNT     = 8;
    localparam int REGS_PER_WIN  = 16;
    localparam int WIN_ENTRIES   = REGS_PER_WIN * WIN_COUNT;
    localparam int WIN_IDX_W     = $clog2(WIN_ENTRIES);
    localparam int GLOBAL_COUNT  = 7;
    localparam int FPR_COUNT     = 32;
    localparam int ASR_DEP_COUNT = 16;
    localparam logic [4:0] WIN_BASE_REG = 5'h08;
    localparam logic [4:0] GLOBAL_LAST  = 5'h07;
    localparam logic [4:0] ASR_DEP_BASE = 5'h10;

    // ****************************************
    // Processor state word fields (low bit positions)
    // ****************************************
    localparam int PSW_IMPL_LO = 28;
    localparam int PSW_VER_LO  = 24;
    localparam int PSW_ICC_LO  = 20;
    localparam int PSW_EC      = 13;
    localparam int PSW_EF      = 12;
    localparam int PSW_PIL_LO  = 8;
    localparam int PSW_S       = 7;
    localparam int PSW_PS      = 6;
    localparam int PSW_ET      = 5;
    localparam int PSW_CWP_LO  = 0;
    // Arbitrary neutral identity values
    localparam logic [3:0] PSW_IMPL_ID = 4'h0;
    localparam logic [3:0] PSW_VER_ID  = 4'h0;

    // ****************************************
    // Trap vector base fields
    // ****************************************
    localparam int TVB_BASE_LO = 12;
    localparam int TVB_TT_LO   = 4;

    // ****************************************
    // Float state word fields
    // ****************************************
    localparam int FSW_RD_LO   = 30;
    localparam int FSW_TEM_LO  = 23;
    localparam int FSW_NS      = 22;
    localparam int FSW_VER_LO  = 17;
    localparam int FSW_FTT_LO  = 14;
    localparam int FSW_QNE     = 13;
    localparam int FSW_FCC_LO  = 10;
    localparam int FSW_AEXC_LO = 5;
    localparam int FSW_CEXC_LO = 0;
    localparam logic [2:0] FSW_VER_ID = 3'h0;

    // Float trap types
    localparam logic [2:0] FTT_IEEE_EXC     = 3'h1;
    localparam logic [2:0] FTT_UNFINISHED   = 3'h2;
    localparam logic [2:0] FTT_UNIMPLEMENTED = 3'h3;
    localparam logic [2:0] FTT_SEQUENCE     = 3'h4;
    localparam logic [2:0] FTT_HARDWARE     = 3'h5;
    localparam logic [2:0] FTT_INVALID_REG  = 3'h6;

    // Trap type codes written into the vector register
    localparam logic [7:0] TT_FLOAT_UNIT = 8'h01;
    localparam logic [7:0] TT_COPROC     = 8'h02;
    localparam logic [7:0] TT_IRQ_BASE   = 8'h10;
    localparam logic [3:0] IRQ_NMI_LEVEL = 4'hF;

    // ****************************************
    // Software port map (byte-free word indices)
    // ****************************************
    localparam logic [7:0] ADR_ARCH_BASE = 8'h00;
    localparam logic [7:0] ADR_FPR_BASE  = 8'h20;
    localparam logic [7:0] ADR_PSW       = 8'h40;
    localparam logic [7:0] ADR_TVB       = 8'h41;
    localparam logic [7:0] ADR_FSW       = 8'h42;
    localparam logic [7:0] ADR_WIM       = 8'h43;
    localparam logic [7:0] ADR_MULAUX    = 8'h44;
    localparam logic [7:0] ADR_PC        = 8'h45;
    localparam logic [7:0] ADR_NPC       = 8'h46;
    localparam logic [7:0] ADR_CTRL      = 8'h47;
    localparam logic [7:0] ADR_STATUS    = 8'h48;
    localparam logic [7:0] ADR_ASR_IND   = 8'h50;
    localparam logic [7:0] ADR_ASR_DEP   = 8'h60;

    // Control and status bits
    localparam int CTRL_WORD_LOCK = 0;
    localparam int CTRL_BYTE_LOCK = 1;
    localparam int STAT_MODE_LO   = 0;
    localparam int STAT_FCC_LO    = 2;
    localparam int STAT_CCC_LO    = 4;
    localparam int STAT_FPU_ATT   = 6;
    localparam int STAT_CP_ATT    = 7;
    localparam int STAT_TRAP_PEND = 8;
    localparam int STAT_IRL_LO    = 12;

    localparam logic [31:0] PC_STEP = 32'h0000_0004;

    typedef enum logic [1:0] {
        WRS_RESET = 2'b00,
        WRS_EXEC  = 2'b01,
        WRS_ERROR = 2'b10
    } wrs_mode_t;

endpackage : wrs_pkg

/* hw/wrs_link_if.sv */
// Interface between the integer unit and its memory, float and coprocessor
`timescale 1ns/10ps
`default_nettype none
interface wrs_link_if;
    logic       fault_state_out;
    logic       atomic_word_lock;
    logic       atomic_byte_lock;
    logic       float_unit_attached;
    logic       float_unit_trap_req;
    logic [1:0] float_branch_flags;
    logic       coproc_attached;
    logic       coproc_trap_req;
    logic [1:0] coproc_branch_flags;
    logic [3:0] interrupt_level_in;
    logic       reset_request_in;

    modport dev (
        output fault_state_out, atomic_word_lock, atomic_byte_lock,
        input  float_unit_attached, float_unit_trap_req, float_branch_flags,
        input  coproc_attached, coproc_trap_req, coproc_branch_flags,
        input  interrupt_level_in, reset_request_in
    );
    modport ext (
        input  fault_state_out, atomic_word_lock, atomic_byte_lock,
        output float_unit_attached, float_unit_trap_req, float_branch_flags,
        output coproc_attached, coproc_trap_req, coproc_branch_flags,
        output interrupt_level_in, reset_request_in
    );
endinterface : wrs_link_if
`default_nettype wire

/* hw/wrs_dev.sv */
// Integer unit architectural state with windowed registers and link end
// Function
// - Fault output high exactly while halted in error
// - Word lock held during atomic swap operations
// - Byte lock held during atomic swap operations
// - Outside drives float unit present input
// - Float unit exception raises float trap
// - Float condition flags resolve float branches
// - Outside drives coprocessor present input
// - Coprocessor exception raises coprocessor trap
// - Coprocessor condition flags resolve coprocessor branches
// - Processor state word field layout
// - Vector register base, type, zero nibble
// - Float state word field layout
// - Seven globals plus sixteen per window
// - Register zero, globals, modulo window mapping
// - Thirty-two float registers
// - Window mask, multiply aux, two counters
// - Ancillary registers reserved low, usable high
// - Float trap type codes one to six
// - Interrupt level, fifteen non-maskable
// - Reset request enters reset, clears fault
`timescale 1ns/10ps
`default_nettype none
module wrs_dev
    import wrs_pkg::*;
(
    // Clock and reset
    input  wire logic  core_clk,
    input  wire logic  rst_b,
    // Software port
    input  wire logic [7:0]  sw_addr,
    input  wire logic [31:0] sw_wdata,
    input  wire logic        sw_wr,
    input  wire logic        sw_rd,
    output logic      [31:0] sw_rdata,
    // Link
    wrs_link_if.dev    link
);

    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        wrs_mode_t                     mode;
        logic                          fault;
        logic                          word_lock;
        logic                          byte_lock;
        logic [3:0]                    irl_s1;
        logic [3:0]                    irl_s2;
        logic                          trap_pend;
        logic [31:0]                   rdata;
        logic [3:0]                    integer_flags;
        logic                          ec;
        logic                          ef;
        logic [3:0]                    interrupt_threshold;
        logic                          s;
        logic                          ps;
        logic                          et;
        logic [4:0]                    current_window_pointer;
        logic [19:0]                   vector_base_field;
        logic [7:0]                    tt;
        logic [1:0]                    rd;
        logic [4:0]                    float_trap_mask;
        logic                          ns;
        logic [2:0]                    ftt;
        logic [1:0]                    fcc;
        logic [4:0]                    aexc;
        logic [4:0]                    cexc;
        logic [31:0]                   invalid_window_mask;
        logic [31:0]                   mulaux;
        logic [31:0]                   pc;
        logic [31:0]                   npc;
        logic [GLOBAL_COUNT-1:0][31:0] glob;
        logic [WIN_ENTRIES-1:0][31:0]  win;
        logic [FPR_COUNT-1:0][31:0]    fpr;
        logic [ASR_DEP_COUNT-1:0][31:0] ancillary_state_reg;
    } wrs_dev_state_t;

    wrs_dev_state_t st;
    wrs_dev_state_t next_st;

    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic [WIN_IDX_W-1:0] win_index(
        input logic [4:0] n,
        input logic [4:0] current_window_pointer
    );
        logic [15:0] full;
        full = 16'(n) - 16'(WIN_BASE_REG) + 16'(current_window_pointer) * 16'(REGS_PER_WIN);
        return WIN_IDX_W'(full % 16'(WIN_ENTRIES));
    endfunction : win_index

    function automatic logic [4:0] cwp_wrap(input logic [4:0] v);
        return 5'(v % 5'(WIN_COUNT));
    endfunction : cwp_wrap

    logic [31:0] psw_word;
    logic [31:0] tvb_word;
    logic [31:0] fsw_word;
    logic [31:0] status_word;
    logic [4:0]  areg;
    logic [3:0]  irl;
    logic        irq_hit;

    assign areg = sw_addr[4:0];
    assign irl  = st.irl_s2;

    always_comb begin
        psw_word = '0;
        psw_word[PSW_IMPL_LO +: 4] = PSW_IMPL_ID;
        psw_word[PSW_VER_LO  +: 4] = PSW_VER_ID;
        psw_word[PSW_ICC_LO  +: 4] = st.integer_flags;
        psw_word[PSW_EC]           = st.ec;
        psw_word[PSW_EF]           = st.ef;
        psw_word[PSW_PIL_LO  +: 4] = st.interrupt_threshold;
        psw_word[PSW_S]            = st.s;
        psw_word[PSW_PS]           = st.ps;
        psw_word[PSW_ET]           = st.et;
        psw_word[PSW_CWP_LO  +: 5] = st.current_window_pointer;
        tvb_word = '0; // Low nibble stays zero
        tvb_word[TVB_BASE_LO +: 20] = st.vector_base_field;
        tvb_word[TVB_TT_LO   +: 8]  = st.tt;
        fsw_word = '0;
        fsw_word[FSW_RD_LO   +: 2] = st.rd;
        fsw_word[FSW_TEM_LO  +: 5] = st.float_trap_mask;
        fsw_word[FSW_NS]           = st.ns;
        fsw_word[FSW_VER_LO  +: 3] = FSW_VER_ID;
        fsw_word[FSW_FTT_LO  +: 3] = st.ftt;
        fsw_word[FSW_FCC_LO  +: 2] = st.fcc;
        fsw_word[FSW_AEXC_LO +: 5] = st.aexc;
        fsw_word[FSW_CEXC_LO +: 5] = st.cexc;
        status_word = '0;
        status_word[STAT_MODE_LO +: 2] = st.mode;
        status_word[STAT_FCC_LO  +: 2] = link.float_branch_flags;
        status_word[STAT_CCC_LO  +: 2] = link.coproc_branch_flags;
        status_word[STAT_FPU_ATT]      = link.float_unit_attached;
        status_word[STAT_CP_ATT]       = link.coproc_attached;
        status_word[STAT_TRAP_PEND]    = st.trap_pend;
        status_word[STAT_IRL_LO  +: 4] = irl;
    end

    // Level fifteen passes the threshold regardless of its value
    assign irq_hit = (irl == IRQ_NMI_LEVEL) || (irl > st.interrupt_threshold);

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        logic       exc;
        logic [7:0] exc_tt;
        next_st = st;
        exc     = 1'b0;
        exc_tt  = '0;
        next_st.irl_s1 = link.interrupt_level_in;
        next_st.irl_s2 = st.irl_s1;

        // Software reads return in the following cycle
        next_st.rdata = '0;
        if (sw_rd) begin
            unique casez (sw_addr)
                8'b000?_????: next_st.rdata = (areg == '0) ? '0 :
                    (areg <= GLOBAL_LAST) ? st.glob[areg - 5'h01] :
                    st.win[win_index(areg, st.current_window_pointer)];
                8'b001?_????: next_st.rdata = st.fpr[areg];
                ADR_PSW:    next_st.rdata = psw_word;
                ADR_TVB:    next_st.rdata = tvb_word;
                ADR_FSW:    next_st.rdata = fsw_word;
                ADR_WIM:    next_st.rdata = st.invalid_window_mask;
                ADR_MULAUX: next_st.rdata = st.mulaux;
                ADR_PC:     next_st.rdata = st.pc;
                ADR_NPC:    next_st.rdata = st.npc;
                ADR_CTRL:   next_st.rdata = {30'h0000_0000, st.byte_lock,
                                             st.word_lock};
                ADR_STATUS: next_st.rdata = status_word;
                8'b0110_????: next_st.rdata = st.ancillary_state_reg[sw_addr[3:0]];
                default:    next_st.rdata = '0;
            endcase
        end

        // Software writes
        if (sw_wr) begin
            unique casez (sw_addr)
                8'b000?_????: begin
                    if (areg == '0) begin
                        next_st.rdata = next_st.rdata;
                    end else if (areg <= GLOBAL_LAST) begin
                        next_st.glob[areg - 5'h01] = sw_wdata;
                    end else begin
                        next_st.win[win_index(areg, st.current_window_pointer)] = sw_wdata;
                    end
                end
                8'b001?_????: next_st.fpr[areg] = sw_wdata;
                ADR_PSW: begin
                    next_st.integer_flags = sw_wdata[PSW_ICC_LO +: 4];
                    next_st.ec  = sw_wdata[PSW_EC];
                    next_st.ef  = sw_wdata[PSW_EF];
                    next_st.interrupt_threshold = sw_wdata[PSW_PIL_LO +: 4];
                    next_st.s   = sw_wdata[PSW_S];
                    next_st.ps  = sw_wdata[PSW_PS];
                    next_st.et  = sw_wdata[PSW_ET];
                    next_st.current_window_pointer = cwp_wrap(sw_wdata[PSW_CWP_LO +: 5]);
                end
                ADR_TVB: next_st.vector_base_field = sw_wdata[TVB_BASE_LO +: 20];
                ADR_FSW: begin
                    next_st.rd   = sw_wdata[FSW_RD_LO +: 2];
                    next_st.float_trap_mask  = sw_wdata[FSW_TEM_LO +: 5];
                    next_st.ns   = sw_wdata[FSW_NS];
                    next_st.ftt  = sw_wdata[FSW_FTT_LO +: 3];
                    next_st.fcc  = sw_wdata[FSW_FCC_LO +: 2];
                    next_st.aexc = sw_wdata[FSW_AEXC_LO +: 5];
                    next_st.cexc = sw_wdata[FSW_CEXC_LO +: 5];
                end
                ADR_WIM:    next_st.invalid_window_mask    = sw_wdata;
                ADR_MULAUX: next_st.mulaux = sw_wdata;
                ADR_PC:     next_st.pc     = sw_wdata;
                ADR_NPC:    next_st.npc    = sw_wdata;
                ADR_CTRL: begin
                    next_st.word_lock = sw_wdata[CTRL_WORD_LOCK];
                    next_st.byte_lock = sw_wdata[CTRL_BYTE_LOCK];
                end
                ADR_STATUS: begin
                    if (sw_wdata[STAT_TRAP_PEND]) begin
                        next_st.trap_pend = 1'b0;
                    end
                end
                8'b0110_????: next_st.ancillary_state_reg[sw_addr[3:0]] = sw_wdata;
                default: ;
            endcase
        end

        // Mode sequencing
        unique case (st.mode)
            WRS_RESET: begin
                next_st.word_lock = 1'b0;
                next_st.byte_lock = 1'b0;
                if (!link.reset_request_in) begin
                    next_st.mode = WRS_EXEC;
                    next_st.pc   = '0;
                    next_st.npc  = PC_STEP;
                    next_st.et   = 1'b0;
                    next_st.s    = 1'b1;
                end
            end
            WRS_EXEC: begin
                if (link.reset_request_in) begin
                    next_st.mode = WRS_RESET;
                end else begin
                    if (link.float_unit_attached && link.float_unit_trap_req) begin
                        exc    = 1'b1;
                        exc_tt = TT_FLOAT_UNIT;
                    end else if (link.coproc_attached && link.coproc_trap_req) begin
                        exc    = 1'b1;
                        exc_tt = TT_COPROC;
                    end
                    if (exc && !st.et) begin
                        // Exception with traps off halts the unit
                        next_st.mode = WRS_ERROR;
                    end else if (st.et && (exc || irq_hit)) begin
                        next_st.tt = exc ? exc_tt : TT_IRQ_BASE + 8'(irl);
                        next_st.et = 1'b0;
                        next_st.ps = st.s;
                        next_st.s  = 1'b1;
                        next_st.current_window_pointer = (st.current_window_pointer == '0) ? 5'(WIN_COUNT - 1) :
                                      st.current_window_pointer - 5'h01;
                        next_st.pc  = {st.vector_base_field, next_st.tt,
                                       4'h0};
                        next_st.npc = {st.vector_base_field, next_st.tt,
                                       4'h0} + PC_STEP;
                        // Set wins over a clear in the same cycle
                        next_st.trap_pend = 1'b1;
                    end
                end
            end
            WRS_ERROR: begin
                if (link.reset_request_in) begin
                    next_st.mode = WRS_RESET;
                end
            end
            default: next_st.mode = WRS_RESET;
        endcase

        next_st.fault = (next_st.mode == WRS_ERROR);
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            st      <= '0;
            st.mode <= WRS_RESET;
        end else begin
            st <= next_st;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign sw_rdata              = st.rdata;
    assign link.fault_state_out  = st.fault;
    assign link.atomic_word_lock = st.word_lock;
    assign link.atomic_byte_lock = st.byte_lock;

endmodule : wrs_dev
`default_nettype wire

/* hw/wrs_ext.sv */
// External system end: memory atomics, float unit and coprocessor drive
`timescale 1ns/10ps
`default_nettype none
module wrs_ext
    import wrs_pkg::*;
(
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        rst_b,
    // Float unit side
    input  wire logic        fpu_fitted,
    input  wire logic        fpu_trap,
    input  wire logic [1:0]  fpu_cond,
    // Coprocessor side
    input  wire logic        cp_fitted,
    input  wire logic        cp_trap,
    input  wire logic [1:0]  cp_cond,
    // System side
    input  wire logic [3:0]  irq_level,
    input  wire logic        sys_reset_req,
    input  wire logic        atomic_req,
    output logic             atomic_grant,
    output logic             fault_seen,
    // Link
    wrs_link_if.ext          link
);

    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        logic       fpu_att;
        logic       fpu_exc;
        logic [1:0] fcc;
        logic       cp_att;
        logic       cp_exc;
        logic [1:0] ccc;
        logic [3:0] irl;
        logic       rst_req;
        logic       grant;
        logic       fault;
    } wrs_ext_state_t;

    wrs_ext_state_t st;
    wrs_ext_state_t next_st;

    always_comb begin
        next_st.fpu_att = fpu_fitted;
        next_st.fpu_exc = fpu_trap;
        next_st.fcc     = fpu_cond;
        next_st.cp_att  = cp_fitted;
        next_st.cp_exc  = cp_trap;
        next_st.ccc     = cp_cond;
        next_st.irl     = irq_level;
        next_st.rst_req = sys_reset_req;
        // A second atomic waits while either lock stands
        next_st.grant   = atomic_req && !link.atomic_word_lock &&
                          !link.atomic_byte_lock;
        next_st.fault   = link.fault_state_out;
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            st         <= '0;
            st.rst_req <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign link.float_unit_attached = st.fpu_att;
    assign link.float_unit_trap_req = st.fpu_exc;
    assign link.float_branch_flags  = st.fcc;
    assign link.coproc_attached     = st.cp_att;
    assign link.coproc_trap_req     = st.cp_exc;
    assign link.coproc_branch_flags = st.ccc;
    assign link.interrupt_level_in  = st.irl;
    assign link.reset_request_in    = st.rst_req;
    assign atomic_grant             = st.grant;
    assign fault_seen               = st.fault;

endmodule : wrs_ext
`default_nettype wire

/* testbench/wrs_chk.sv */
// Link checker for the integer unit and its external system
`timescale 1ns/10ps
`default_nettype none
module wrs_chk (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // Link signals
    input wire logic fault_state_out,
    input wire logic atomic_word_lock,
    input wire logic atomic_byte_lock,
    input wire logic float_unit_attached,
    input wire logic float_unit_trap_req,
    input wire logic coproc_attached,
    input wire logic coproc_trap_req,
    input wire logic reset_request_in
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    // A trap request only counts with its unit fitted
    wire logic exc = (float_unit_trap_req && float_unit_attached)
                   || (coproc_trap_req && coproc_attached);
    sequence reset_held;
        reset_request_in [*3];
    endsequence
    sequence calm;
        !fault_state_out && !reset_request_in && !exc;
    endsequence
    fault_clear_a: assert property (
        reset_request_in |=> !fault_state_out) else $error("fault stuck");
    fault_quiet_a: assert property (
        fault_state_out |-> !$past(reset_request_in)) else $error("fault");
    fault_hold_a: assert property (
        fault_state_out && !reset_request_in |=> fault_state_out)
        else $error("fault dropped early");
    fault_fall_a: assert property (
        $fell(fault_state_out) |-> $past(reset_request_in))
        else $error("fault fell without reset");
    fault_rise_a: assert property (
        $rose(fault_state_out) |-> $past(exc)) else $error("fault no cause");
    trap_guard_a: assert property (
        calm |=> !fault_state_out) else $error("fault without trap");
    word_lock_rst_a: assert property (
        reset_held |-> !atomic_word_lock) else $error("word lock in reset");
    byte_lock_rst_a: assert property (
        reset_held |-> !atomic_byte_lock) else $error("byte lock in reset");
endmodule : wrs_chk
`default_nettype wire

/* testbench/tb_top.sv */
// Self-checking bench for both link ends and the software port
`timescale 1ns/10ps
`default_nettype none
module tb_top
    import wrs_pkg::*;
;
    logic        core_clk = 1'b0;
    logic        rst_b = 1'b0;
    logic [7:0]  sw_addr = 8'h00;
    logic [31:0] sw_wdata = 32'h0000_0000;
    logic        sw_wr = 1'b0, sw_rd = 1'b0;
    logic        fpu_fitted = 1'b0, fpu_trap = 1'b0, cp_fitted = 1'b0;
    logic        cp_trap = 1'b0, sys_reset_req = 1'b0, atomic_req = 1'b0;
    logic [1:0]  fpu_cond = 2'h0, cp_cond = 2'h0;
    logic [3:0]  irq_level = 4'h0;
    logic [31:0] sw_rdata, d;
    logic        atomic_grant, fault_seen;
    int          miscompares = 0, n_tests = 0;
    logic [2:0]  ftt [6] = '{FTT_IEEE_EXC, FTT_UNFINISHED, FTT_UNIMPLEMENTED,
                            FTT_SEQUENCE, FTT_HARDWARE, FTT_INVALID_REG};
    always #5 core_clk = ~core_clk;
    wrs_link_if lnk ();
    wrs_dev i_wrs_dev (.core_clk, .rst_b, .sw_addr, .sw_wdata, .sw_wr,
        .sw_rd, .sw_rdata, .link(lnk));
    wrs_ext i_wrs_ext (.core_clk, .rst_b, .fpu_fitted, .fpu_trap, .fpu_cond,
        .cp_fitted, .cp_trap, .cp_cond, .irq_level, .sys_reset_req,
        .atomic_req, .atomic_grant, .fault_seen, .link(lnk));
    wrs_chk i_wrs_chk (.core_clk, .rst_b,
        .fault_state_out(lnk.fault_state_out),
        .atomic_word_lock(lnk.atomic_word_lock),
        .atomic_byte_lock(lnk.atomic_byte_lock),
        .float_unit_attached(lnk.float_unit_attached),
        .float_unit_trap_req(lnk.float_unit_trap_req),
        .coproc_attached(lnk.coproc_attached),
        .coproc_trap_req(lnk.coproc_trap_req),
        .reset_request_in(lnk.reset_request_in));
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_tests++;
        if (g !== e) begin
            miscompares++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk
    // Step past the edge so sampled outputs have settled
    task automatic settle(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : settle
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge core_clk);
        sw_wr <= 1'b1;
        sw_addr <= a;
        sw_wdata <= v;
        @(posedge core_clk);
        sw_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        @(posedge core_clk);
        sw_rd <= 1'b1;
        sw_addr <= a;
        @(posedge core_clk);
        sw_rd <= 1'b0;
        #1 d = sw_rdata;
    endtask : rd
    task automatic rc(input logic [7:0] a, input logic [31:0] e);
        rd(a);
        chk(d, e);
    endtask : rc
    // One-cycle request, as a held one would halt in error once the first trap clears the trap enable
    task automatic trap_pulse(input logic flt);
        @(posedge core_clk);
        fpu_trap <= flt;
        cp_trap <= !flt;
        @(posedge core_clk);
        fpu_trap <= 1'b0;
        cp_trap <= 1'b0;
        settle(4);
    endtask : trap_pulse
    task automatic complete_run;
        $display("Comparisons %0d, mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : complete_run
    initial begin
        #20000;
        miscompares++;
        complete_run();
    end
    initial begin
        repeat (4) @(posedge core_clk);
        rst_b <= 1'b1;
        settle(4);
        rc(ADR_STATUS, 32'h0000_0001);
        rc(ADR_NPC, 32'h0000_0004);
        rc(ADR_PSW, 32'h0000_0080);
        wr(ADR_ARCH_BASE, 32'hDEAD_BEEF);
        rc(ADR_ARCH_BASE, 32'h0000_0000);
        wr(8'h07, 32'h7777_0007);
        wr(8'h18, 32'h1111_2222);
        wr(8'h08, 32'h3333_4444);
        wr(ADR_PSW, 32'h0000_0081);
        rc(8'h08, 32'h1111_2222);
        wr(ADR_PSW, 32'h0000_0087);
        rc(8'h18, 32'h3333_4444);
        rc(8'h07, 32'h7777_0007);
        wr(ADR_FPR_BASE + 8'h1F, 32'h0F0F_1234);
        rc(ADR_FPR_BASE + 8'h1F, 32'h0F0F_1234);
        wr(ADR_FSW, 32'hFFFF_FFFF);
        rc(ADR_FSW, 32'hCFC1_CFFF);
        for (int i = 0; i < 6; i++) begin
            wr(ADR_FSW, {15'h0, ftt[i], 14'h0});
            rc(ADR_FSW, {15'h0, 3'(i + 1), 14'h0});
        end
        wr(ADR_ASR_IND + 8'h01, 32'hFFFF_FFFF);
        rc(ADR_ASR_IND + 8'h01, 32'h0000_0000);
        wr(ADR_ASR_DEP + 8'h0F, 32'h5A5A_5A5A);
        rc(ADR_ASR_DEP + 8'h0F, 32'h5A5A_5A5A);
        wr(ADR_WIM, 32'hA5A5_0F0F);
        rc(ADR_WIM, 32'hA5A5_0F0F);
        wr(ADR_MULAUX, 32'h0123_4567);
        rc(ADR_MULAUX, 32'h0123_4567);
        wr(ADR_TVB, 32'hFFFF_FFFF);
        rc(ADR_TVB, 32'hFFFF_F000);
        wr(ADR_TVB, 32'h1234_5000);
        trap_pulse(1'b1);
        chk({31'h0, lnk.fault_state_out}, 32'h0);
        @(posedge core_clk);
        fpu_fitted <= 1'b1;
        fpu_cond <= 2'h2;
        cp_fitted <= 1'b1;
        cp_cond <= 2'h1;
        settle(3);
        rc(ADR_STATUS, 32'h0000_00D9);
        wr(ADR_PSW, 32'h0000_00A0);
        trap_pulse(1'b1);
        rc(ADR_TVB, 32'h1234_5010);
        rc(ADR_PSW, 32'h0000_00C7);
        rc(ADR_PC, 32'h1234_5010);
        wr(ADR_PSW, 32'h0000_00A0);
        trap_pulse(1'b0);
        rc(ADR_TVB, 32'h1234_5020);
        wr(ADR_PSW, 32'h0000_0FA0);
        irq_level <= 4'hF;
        repeat (6) @(posedge core_clk);
        irq_level <= 4'h0;
        rc(ADR_TVB, 32'h1234_51F0);
        @(posedge core_clk);
        atomic_req <= 1'b1;
        wr(ADR_CTRL, 32'h0000_0003);
        settle(3);
        chk({30'h0, lnk.atomic_byte_lock, lnk.atomic_word_lock}, 32'h3);
        chk({31'h0, atomic_grant}, 32'h0);
        wr(ADR_CTRL, 32'h0000_0000);
        settle(3);
        chk({31'h0, atomic_grant}, 32'h1);
        trap_pulse(1'b1);
        chk({31'h0, lnk.fault_state_out}, 32'h1);
        rd(ADR_STATUS);
        chk({30'h0, d[1:0]}, 32'h2);
        chk({31'h0, fault_seen}, 32'h1);
        // Locks up going into reset, so the reset clear is really exercised
        wr(ADR_CTRL, 32'h0000_0003);
        sys_reset_req <= 1'b1;
        settle(4);
        chk({31'h0, lnk.fault_state_out}, 32'h0);
        @(posedge core_clk);
        sys_reset_req <= 1'b0;
        settle(3);
        rc(ADR_STATUS, 32'h0000_01D9);
        rc(ADR_CTRL, 32'h0000_0000);
        wr(ADR_STATUS, 32'h0000_0100);
        rc(ADR_STATUS, 32'h0000_00D9);
        complete_run();
    end
endmodule : tb_top
`default_nettype wire
